// ### verilog/icp_pkg.sv
// package: register map, field positions, modes and carrier types of the i2c port control block
package icp_pkg;
  localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
  localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
  localparam logic [7:0] OFS_BUFFER = 8'h08;
  localparam logic [7:0] OFS_ADDR = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST = 8'h00;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'hff;
  localparam int B_COLL = 7;
  localparam int B_OVFL = 6;
  localparam int B_EN = 5;
  localparam int B_REL = 4;
  localparam int B_GCALL = 7;
  localparam int B_ACKST = 6;
  localparam int B_ACK_DATA = 5;
  localparam int B_ACK_GO = 4;
  localparam int B_RX_GO = 3;
  localparam int B_STOP_GO = 2;
  localparam int B_RS_GO = 1;
  localparam int B_START_GO = 0;
  localparam int S_FULL = 0;
  localparam int S_ACTIVE = 1;
  localparam int S_EVENT = 2;
  localparam int S_RW = 3;
  localparam logic [3:0] MODE_SLV7 = 4'h6;
  localparam logic [3:0] MODE_SLV10 = 4'h7;
  localparam logic [3:0] MODE_MST = 4'h8;
  localparam logic [3:0] MODE_MASKLD = 4'h9;
  localparam logic [3:0] MODE_FWMST = 4'hb;
  localparam logic [3:0] MODE_SLV7SS = 4'he;
  localparam logic [3:0] MODE_SLV10SS = 4'hf;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } icp_apb_t;
  typedef struct packed {
    logic scl;
    logic sda;
  } icp_pins_t;
  typedef enum logic [2:0] {M_IDLE, M_START, M_RSTART, M_STOP, M_TX, M_RX, M_ACK} icp_mst_t;
  typedef enum logic [1:0] {SL_IDLE, SL_ADDR, SL_RX, SL_TX} icp_slv_t;
endpackage

// ### verilog/icp_port.sv
// i2c port control: control registers, master sequencer and slave byte engine behind apb
`timescale 1ns/1ps

// Notes on behaviour
// [RULE1] buffer write while master busy or slave mid-byte in transmit sets collision flag; software clears
// [RULE2] byte arriving while buffer still full sets overflow flag; software clears
// [RULE3] port enable hands both pins to the port; clear returns them to io
// [RULE4] in slave mode clock held low while release bit is zero
// [RULE5] modes 6 and 7 slave 7/10-bit; e and f add start/stop events
// [RULE6] mode 8 master, quarter bit lasts reload plus one clocks
// [RULE7] mode b is firmware master, slave engine idle
// [RULE8] mode 9 redirects address register accesses to the mask register
// [RULE9] mask access mode only when seven-bit masking style strap is one
// [RULE10] unlisted mode codes do nothing on the bus
// [RULE11] general call address raises event only when enabled
// [RULE12] master transmit stores slave acknowledge in ack status, one means none
// [RULE13] master receive acknowledge bit drives ack data value
// [RULE14] ack trigger runs acknowledge sequence then clears itself
// [RULE15] receive trigger makes master receive one byte, else receiver idle
// [RULE16] stop trigger generates stop condition then clears itself
// [RULE17] repeated start trigger generates repeated start then clears itself
// [RULE18] start trigger generates start condition then clears itself
// [RULE19] while active, trigger writes and buffer writes are ignored
// [RULE20] slave mask bits five to two make address bits don't care
// [RULE21] low mask bit masks address bit one, or bits one and zero for 10-bit
// [RULE22] slave stretch enable bit turns clock stretching on or off
// [RULE23] each trigger clears in the cycle its sequence completes
module icp_port (
  input wire logic clock_in, // system clock
  input wire logic rstn_in, // async reset, active low
  input wire icp_pkg::icp_apb_t apb_in, // apb request
  output logic [31:0] prdata_out, // apb read data
  output logic pready_out, // apb ready
  output logic pslverr_out, // apb error on unmapped address
  input wire logic masking_style_config_in, // one selects seven-bit mask register style
  input wire icp_pkg::icp_pins_t pins_in, // sampled bus levels
  output icp_pkg::icp_pins_t pins_out, // pin output values, always low
  output icp_pkg::icp_pins_t pins_oe_out, // pin pull-low enables
  output logic port_owned_out, // pins belong to the port
  output logic event_out // sticky slave event flag
);
  import icp_pkg::*;

  function automatic logic is_slave(input logic [3:0] m);
    return (m == MODE_SLV7) || (m == MODE_SLV10) || (m == MODE_SLV7SS) || (m == MODE_SLV10SS);
  endfunction

  function automatic logic is_master(input logic [3:0] m);
    return (m == MODE_MST) || (m == MODE_FWMST);
  endfunction

  function automatic logic addr_hit(input logic [7:0] rx, input logic [7:0] adr, input logic [7:0] msk,
                                    input logic ten);
    logic [7:0] care;
    care = ten ? ~msk : {~msk[7:1], 1'b0};
    return ((rx ^ adr) & care) == 8'h00;
  endfunction

  logic rst_meta_q;
  logic rst_n;
  logic [7:0] c1_q;
  logic [7:0] c2_q;
  logic [7:0] buf_q;
  logic [7:0] addr_q;
  logic [7:0] mask_q;
  logic full_q;
  logic event_q;
  logic rw_q;
  logic pready_q;
  icp_pins_t prev_q;
  icp_mst_t m_state_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [7:0] m_sh_q;
  logic m_hold_q;
  logic m_sdah_q;
  logic [6:0] baud_q;
  icp_slv_t s_state_q;
  logic [3:0] s_cnt_q;
  logic [7:0] s_sh_q;
  logic s_sda_low_q;
  logic m_scl_low;
  logic m_sda_low;
  logic [7:0] rdata;
  logic rhit;

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  wire [3:0] mode = c1_q[3:0];
  wire en = c1_q[B_EN];
  wire mst = en && is_master(mode); // [RULE10]
  wire slv = en && is_slave(mode); // [RULE7] [RULE10]
  wire ten = (mode == MODE_SLV10) || (mode == MODE_SLV10SS); // [RULE5]
  wire ss_int = slv && mode[3]; // [RULE5]
  wire mask_sel = (mode == MODE_MASKLD) && masking_style_config_in; // [RULE8] [RULE9]
  wire [7:0] wd = apb_in.pwdata[7:0];
  wire acc = apb_in.psel && apb_in.penable;
  wire done = acc && pready_q;
  wire wr = done && apb_in.pwrite;
  wire rd = done && !apb_in.pwrite;

  // master sequencer status
  wire m_active = mst && ((m_state_q != M_IDLE) || (|c2_q[4:0]));
  wire tick = (baud_q == 7'h00);
  wire [3:0] last_bit = (m_state_q == M_TX) ? 4'd8 : ((m_state_q == M_RX) ? 4'd7 : 4'd0);
  wire end_seq = (m_state_q != M_IDLE) && tick && (ph_q == 2'd3) && (bit_q == last_bit);
  wire samp = (m_state_q != M_IDLE) && tick && (ph_q == 2'd2);
  wire m_rx_done = end_seq && (m_state_q == M_RX);

  // slave edge and condition detection
  wire scl_r = pins_in.scl && !prev_q.scl;
  wire scl_f = !pins_in.scl && prev_q.scl;
  wire st_c = prev_q.scl && pins_in.scl && prev_q.sda && !pins_in.sda;
  wire sp_c = prev_q.scl && pins_in.scl && !prev_q.sda && pins_in.sda;
  wire s_live = slv && !st_c && !sp_c;
  wire s_fall8 = s_live && scl_f && (s_cnt_q == 4'd8);
  wire s_fall9 = s_live && scl_f && (s_cnt_q == 4'd9);
  // mask bit n of control two lines up with address bit n; the low bit also covers bit 0 for 10-bit
  wire [7:0] eff_mask = masking_style_config_in ? mask_q : {2'b00, c2_q[5:2], c2_q[1], ten & c2_q[1]}; // [RULE20] [RULE21]
  wire gcall = (s_sh_q == 8'h00) && c2_q[B_GCALL]; // [RULE11]
  wire s_addr_ok = (s_state_q == SL_ADDR) && (addr_hit(s_sh_q, addr_q, eff_mask, ten) || gcall);
  wire s_byte = s_fall8 && (s_addr_ok || (s_state_q == SL_RX));
  wire s_take = s_byte && !full_q && !c1_q[B_OVFL];
  wire s_tx_busy = (s_state_q == SL_TX) && (s_cnt_q != 4'd0) && (s_cnt_q < 4'd9);

  // side effects of buffer traffic and slave bus events
  wire buf_wr = wr && (apb_in.paddr == OFS_BUFFER);
  wire coll_set = buf_wr && ((mst && m_active) || (slv && s_tx_busy)); // [RULE1] [RULE19]
  wire buf_ok = buf_wr && !coll_set;
  wire ovf_set = (m_rx_done && full_q) || (s_fall8 && (s_state_q == SL_RX) && full_q); // [RULE2]
  wire rel_clr = s_fall9 && c2_q[0]; // [RULE22]
  wire ev_set = s_byte || (s_fall9 && (s_state_q == SL_TX)) || (ss_int && (st_c || sp_c));

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      c1_q <= CTRL_ONE_RST;
    end else begin
      if (rel_clr) begin
        c1_q[B_REL] <= 1'b0;
      end
      if (wr && (apb_in.paddr == OFS_CTRL_ONE)) begin
        c1_q <= wd;
      end
      // hardware set lands after the software write so a coinciding event wins
      if (coll_set) begin
        c1_q[B_COLL] <= 1'b1; // [RULE1]
      end
      if (ovf_set) begin
        c1_q[B_OVFL] <= 1'b1; // [RULE2]
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      c2_q <= CTRL_TWO_RST;
    end else begin
      if (wr && (apb_in.paddr == OFS_CTRL_TWO)) begin
        c2_q[B_GCALL] <= wd[B_GCALL];
        c2_q[B_ACK_DATA] <= wd[B_ACK_DATA];
        if (!m_active) begin
          c2_q[4:0] <= wd[4:0]; // [RULE19]
        end
      end
      if (samp && (m_state_q == M_TX) && (bit_q == 4'd8)) begin
        c2_q[B_ACKST] <= pins_in.sda; // [RULE12]
      end
      if (end_seq) begin
        case (m_state_q)
          M_START: c2_q[B_START_GO] <= 1'b0; // [RULE18] [RULE23]
          M_RSTART: c2_q[B_RS_GO] <= 1'b0; // [RULE17] [RULE23]
          M_STOP: c2_q[B_STOP_GO] <= 1'b0; // [RULE16] [RULE23]
          M_RX: c2_q[B_RX_GO] <= 1'b0; // [RULE15] [RULE23]
          M_ACK: c2_q[B_ACK_GO] <= 1'b0; // [RULE14] [RULE23]
          default: ;
        endcase
      end
      if (!mst && !slv) begin
        c2_q[4:0] <= c2_q[4:0];
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= ADDR_RST;
      mask_q <= MASK_RST;
    end else if (wr && (apb_in.paddr == OFS_ADDR)) begin
      if (mask_sel) begin
        mask_q <= wd; // [RULE8]
      end else begin
        addr_q <= wd;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      buf_q <= 8'h00;
      full_q <= 1'b0;
    end else begin
      if (rd && (apb_in.paddr == OFS_BUFFER)) begin
        full_q <= 1'b0;
      end
      if (end_seq && (m_state_q == M_TX)) begin
        full_q <= 1'b0;
      end
      if (slv && scl_r && (s_state_q == SL_TX) && (s_cnt_q == 4'd0)) begin
        full_q <= 1'b0;
      end
      if (buf_ok) begin
        buf_q <= wd; // [RULE19]
        full_q <= 1'b1;
      end
      if ((m_rx_done && !full_q) || s_take) begin
        buf_q <= m_rx_done ? m_sh_q : s_sh_q;
        full_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      event_q <= 1'b0;
    end else begin
      if (wr && (apb_in.paddr == OFS_STATUS) && wd[S_EVENT]) begin
        event_q <= 1'b0;
      end
      if (ev_set) begin
        event_q <= 1'b1; // [RULE11] [RULE5]
      end
    end
  end

  // quarter-bit timer: scl = clock / (4 * (reload + 1))
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      baud_q <= 7'h00;
    end else if ((m_state_q == M_IDLE) || tick) begin
      baud_q <= addr_q[6:0]; // [RULE6]
    end else begin
      baud_q <= baud_q - 7'h01;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      m_state_q <= M_IDLE;
      ph_q <= 2'd0;
      bit_q <= 4'd0;
      m_sh_q <= 8'h00;
      m_hold_q <= 1'b0;
      m_sdah_q <= 1'b0;
    end else if (!mst) begin
      m_state_q <= M_IDLE;
      ph_q <= 2'd0;
      bit_q <= 4'd0;
      m_hold_q <= 1'b0;
      m_sdah_q <= 1'b0;
    end else if (m_state_q == M_IDLE) begin
      ph_q <= 2'd0;
      bit_q <= 4'd0;
      if (c2_q[B_START_GO]) begin
        m_state_q <= M_START; // [RULE18]
      end else if (c2_q[B_RS_GO]) begin
        m_state_q <= M_RSTART; // [RULE17]
      end else if (c2_q[B_STOP_GO]) begin
        m_state_q <= M_STOP; // [RULE16]
      end else if (c2_q[B_RX_GO]) begin
        m_state_q <= M_RX; // [RULE15]
      end else if (c2_q[B_ACK_GO]) begin
        m_state_q <= M_ACK; // [RULE14]
      end else if (buf_ok) begin
        m_state_q <= M_TX;
        m_sh_q <= wd;
      end
    end else begin
      if (tick) begin
        ph_q <= ph_q + 2'd1;
        if (ph_q == 2'd3) begin
          bit_q <= bit_q + 4'd1;
        end
      end
      if (samp && (m_state_q == M_RX)) begin
        m_sh_q <= {m_sh_q[6:0], pins_in.sda};
      end
      if (tick && (ph_q == 2'd3) && (m_state_q == M_TX) && (bit_q < 4'd8)) begin
        m_sh_q <= {m_sh_q[6:0], 1'b0};
      end
      if (end_seq) begin
        m_state_q <= M_IDLE;
        // after anything but stop the master keeps scl low to own the bus
        m_hold_q <= (m_state_q != M_STOP);
        m_sdah_q <= (m_state_q == M_START) || (m_state_q == M_RSTART);
      end
    end
  end

  always_comb begin
    m_scl_low = 1'b0;
    m_sda_low = 1'b0;
    case (m_state_q)
      M_IDLE: begin
        m_scl_low = m_hold_q;
        m_sda_low = m_sdah_q;
      end
      M_START: begin
        m_scl_low = (ph_q == 2'd3); // [RULE18]
        m_sda_low = (ph_q != 2'd0);
      end
      M_RSTART: begin
        m_scl_low = (ph_q[1] == ph_q[0]); // [RULE17]
        m_sda_low = ph_q[1];
      end
      M_STOP: begin
        m_scl_low = (ph_q == 2'd0); // [RULE16]
        m_sda_low = !ph_q[1];
      end
      M_TX: begin
        m_scl_low = (ph_q[1] == ph_q[0]);
        m_sda_low = (bit_q < 4'd8) && !m_sh_q[7];
      end
      M_RX: begin
        m_scl_low = (ph_q[1] == ph_q[0]); // [RULE15]
      end
      M_ACK: begin
        m_scl_low = (ph_q[1] == ph_q[0]);
        m_sda_low = !c2_q[B_ACK_DATA]; // [RULE13] [RULE14]
      end
      default: ;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= '0;
    end else begin
      prev_q <= pins_in;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      s_state_q <= SL_IDLE;
      s_cnt_q <= 4'd0;
      s_sh_q <= 8'h00;
      s_sda_low_q <= 1'b0;
      rw_q <= 1'b0;
    end else if (!slv) begin
      s_state_q <= SL_IDLE; // [RULE7]
      s_cnt_q <= 4'd0;
      s_sda_low_q <= 1'b0;
    end else if (st_c || sp_c) begin
      s_state_q <= st_c ? SL_ADDR : SL_IDLE;
      s_cnt_q <= 4'd0;
      s_sda_low_q <= 1'b0;
    end else if (s_state_q != SL_IDLE) begin
      if (scl_r && (s_cnt_q < 4'd8)) begin
        s_sh_q <= {s_sh_q[6:0], pins_in.sda};
        s_cnt_q <= s_cnt_q + 4'd1;
      end
      if (scl_r && (s_cnt_q == 4'd8) && (s_state_q == SL_TX) && pins_in.sda) begin
        s_state_q <= SL_IDLE;
      end
      // first transmit bit follows the buffer until the clock rises
      if ((s_state_q == SL_TX) && (s_cnt_q == 4'd0) && !pins_in.scl) begin
        s_sh_q <= buf_q;
        s_sda_low_q <= !buf_q[7];
      end
      if (scl_f) begin
        if (s_cnt_q == 4'd8) begin
          s_sda_low_q <= s_take;
          s_cnt_q <= 4'd9;
          if (s_state_q == SL_ADDR) begin
            s_state_q <= s_addr_ok ? (s_sh_q[0] ? SL_TX : SL_RX) : SL_IDLE; // [RULE20]
            rw_q <= s_addr_ok ? s_sh_q[0] : rw_q;
          end
        end else if (s_cnt_q == 4'd9) begin
          s_sda_low_q <= 1'b0;
          s_cnt_q <= 4'd0;
        end else if ((s_state_q == SL_TX) && (s_cnt_q != 4'd0)) begin
          s_sda_low_q <= !s_sh_q[7];
        end
      end
    end
  end

  always_comb begin
    rdata = 8'h00;
    rhit = 1'b1;
    case (apb_in.paddr)
      OFS_CTRL_ONE: rdata = c1_q;
      OFS_CTRL_TWO: rdata = c2_q;
      OFS_BUFFER: rdata = buf_q;
      OFS_ADDR: rdata = mask_sel ? mask_q : addr_q; // [RULE8]
      OFS_STATUS: rdata = {4'h0, rw_q, event_q, m_active, full_q};
      default: rhit = 1'b0;
    endcase
  end

  // one wait state: ready rises in the second access cycle
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      prdata_out <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else begin
      pready_q <= acc && !pready_q;
      if (acc && !pready_q) begin
        prdata_out <= {24'h00_0000, rdata};
        pslverr_out <= !rhit;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      pins_oe_out <= '0;
      pins_out <= '0;
      port_owned_out <= 1'b0;
    end else begin
      pins_oe_out.scl <= en && ((mst && m_scl_low) || (slv && !c1_q[B_REL])); // [RULE4]
      pins_oe_out.sda <= en && ((mst && m_sda_low) || (slv && s_sda_low_q));
      pins_out <= '0;
      port_owned_out <= en; // [RULE3]
    end
  end

  assign pready_out = pready_q;
  assign event_out = event_q;
endmodule

// ### tb/icp_port_assertions.sv
// checker: port-level assertions for the i2c port control block
`timescale 1ns/1ps
module icp_port_assertions (
  input wire logic clock_in, // system clock
  input wire logic rstn_in, // async reset, active low
  input wire icp_pkg::icp_apb_t apb_in, // apb request
  input wire logic pready_out, // apb ready
  input wire icp_pkg::icp_pins_t pins_out, // pin values
  input wire icp_pkg::icp_pins_t pins_oe_out, // pin pull-low enables
  input wire logic port_owned_out // pins owned by the port
);
  import icp_pkg::*;
  logic en_q, rel_q, st_q;
  logic [3:0] mode_q;
  wire wr_w = apb_in.psel && apb_in.penable && apb_in.pwrite && pready_out;
  wire slv_w = mode_q inside {MODE_SLV7, MODE_SLV10, MODE_SLV7SS, MODE_SLV10SS};
  wire mst_w = mode_q inside {MODE_MST, MODE_FWMST};
  // mirror of the pin-steering bits; stretch is kept only from slave-mode writes since bit0 self-clears as a trigger
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      {en_q, rel_q, mode_q, st_q} <= 7'h00;
    end else if (wr_w && apb_in.paddr == OFS_CTRL_ONE) begin
      {en_q, rel_q, mode_q} <= apb_in.pwdata[5:0];
    end else if (wr_w && apb_in.paddr == OFS_CTRL_TWO) begin
      st_q <= slv_w && apb_in.pwdata[0];
    end
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  owned_follow_a: assert property (en_q == $past(en_q) && en_q == $past(en_q, 2) |-> port_owned_out == en_q)
    else $error("port ownership differs from enable bit");
  released_pins_a: assert property (!port_owned_out [*3] |-> pins_oe_out == 2'b00)
    else $error("pin pulled while port disabled");
  open_drain_a: assert property (pins_out == 2'b00)
    else $error("pin driven high");
  slave_hold_a: assert property ((en_q && slv_w && !rel_q) [*4] |-> pins_oe_out.scl)
    else $error("clock not held in slave mode");
  clock_release_a: assert property ((en_q && slv_w && rel_q && !st_q) [*4] |-> !pins_oe_out.scl)
    else $error("clock held although released");
  reserved_idle_a: assert property ((!slv_w && !mst_w) [*4] |-> pins_oe_out == 2'b00)
    else $error("bus activity in idle mode");
  start_cond_a: assert property (mst_w && $rose(pins_oe_out.sda) && !pins_oe_out.scl |=>
    pins_oe_out.sda && !pins_oe_out.scl) else $error("clock fell with data in start");
  stop_cond_a: assert property (mst_w && $fell(pins_oe_out.sda) && !pins_oe_out.scl |=>
    !pins_oe_out.sda && !pins_oe_out.scl) else $error("bus not idle after stop");
endmodule

bind icp_port icp_port_assertions u_chk (.clock_in(clock_in), .rstn_in(rstn_in), .apb_in(apb_in),
  .pready_out(pready_out), .pins_out(pins_out), .pins_oe_out(pins_oe_out), .port_owned_out(port_owned_out));

// ### tb/icp_bus_target.sv
// partner: behavioural i2c target that acknowledges the first byte written after a start and returns one byte on reads
`timescale 1ns/1ps
module icp_bus_target (
  input wire logic scl_in, // bus clock line
  input wire logic sda_in, // bus data line
  input wire logic ack_en_in, // acknowledge the first byte sent here after a start
  input wire logic read_in, // return rd_byte_in after start
  input wire logic [7:0] rd_byte_in, // byte returned on reads
  output logic sda_pull_out // pull data line low
);
  int cnt;
  initial begin
    cnt = 9;
    sda_pull_out = 1'b0;
  end
  // start or repeated start restarts the bit count
  always @(negedge sda_in) begin
    if (scl_in) begin
      cnt = -1;
    end
  end
  // data changes only while the clock is low; released otherwise so the pull-up wins
  always @(negedge scl_in) begin
    cnt = cnt + 1;
    if (read_in) begin
      sda_pull_out = (cnt < 8) && !rd_byte_in[7 - cnt];
    end else begin
      sda_pull_out = (cnt == 8) && ack_en_in;
    end
  end
endmodule

// ### tb/tb.sv
// testbench: apb-driven checks of the i2c port control registers and master sequences
`timescale 1ns/1ps
module tb;
  import icp_pkg::*;
  logic clock_in, rstn_in, strap, ack_en, rd_mode, p_sda, scl_w, sda_w, prdy, perr, err, owned;
  icp_apb_t apb;
  icp_pins_t pin, po, poe;
  logic [31:0] prd, rd;
  logic [8:0] wire_sh;
  logic [3:0] mode_tab [8] = '{MODE_SLV7, MODE_SLV10, MODE_SLV7SS, MODE_SLV10SS, MODE_MST, MODE_FWMST, 4'h3,
    MODE_MASKLD};
  logic [7:0] hold_m = 8'h0f;
  logic [7:0] tx_tab [2] = '{8'ha5, 8'h3c};
  logic [7:0] sl_tab [3] = '{8'ha4, 8'h00, 8'ha8};
  logic m_scl_lo, m_sda_lo, evt, ack;
  int error_cnt, num_checks, cyc;
  assign scl_w = !(poe.scl || m_scl_lo);
  assign sda_w = !(poe.sda || p_sda || m_sda_lo);
  assign pin = {scl_w, sda_w};
  icp_port dut (.clock_in(clock_in), .rstn_in(rstn_in), .apb_in(apb), .prdata_out(prd), .pready_out(prdy),
    .pslverr_out(perr), .masking_style_config_in(strap), .pins_in(pin), .pins_out(po), .pins_oe_out(poe),
    .port_owned_out(owned), .event_out(evt));
  icp_bus_target part (.scl_in(scl_w), .sda_in(sda_w), .ack_en_in(ack_en), .read_in(rd_mode),
    .rd_byte_in(8'h96), .sda_pull_out(p_sda));
  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = !clock_in;
  end
  always @(posedge scl_w) wire_sh <= {wire_sh[7:0], sda_w};
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt = error_cnt + 1;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one idle cycle between transfers keeps every request signal to one assignment per time step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock_in);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
    @(posedge clock_in);
    apb.penable <= 1'b1;
    do begin
      @(posedge clock_in);
      n++;
    end while (prdy !== 1'b1 && n < 100);
    rd = prd;
    err = perr;
    apb <= '0;
  endtask
  task automatic bus_step(input logic c, input logic d);
    m_scl_lo <= c;
    m_sda_lo <= d;
    repeat (4) @(posedge clock_in);
  endtask
  // bench as a bus master on the lines: start, one byte, acknowledge slot, stop
  task automatic frame(input logic [7:0] b, output logic a);
    bus_step(1'b0, 1'b1);
    for (int j = 7; j >= 0; j--) begin
      bus_step(1'b1, !b[j]);
      bus_step(1'b0, !b[j]);
    end
    bus_step(1'b1, 1'b0);
    bus_step(1'b0, 1'b0);
    a = !sda_w;
    bus_step(1'b1, 1'b0);
    bus_step(1'b1, 1'b1);
    bus_step(1'b0, 1'b1);
    bus_step(1'b0, 1'b0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(rd & {24'hffffff, m}, {24'h0, e});
  endtask
  task automatic poll(input logic [7:0] a, input logic [7:0] m);
    int k;
    k = 0;
    do begin
      xfer(1'b0, a, 8'h00);
      k++;
    end while ((rd[7:0] & m) != 8'h00 && k < 400);
    chk(rd & {24'h0, m}, 32'h0);
  endtask
  initial begin
    apb = '0;
    {strap, ack_en, rd_mode, rstn_in, wire_sh} = {4'b1100, 9'h0};
    {error_cnt, num_checks, cyc} = '0;
    {m_scl_lo, m_sda_lo} = 2'b00;
    repeat (2) @(posedge clock_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    rdc(OFS_CTRL_ONE, 8'hff, CTRL_ONE_RST);
    rdc(OFS_CTRL_TWO, 8'hff, CTRL_TWO_RST);
    rdc(8'h14, 8'hff, 8'h00);
    chk({31'h0, err}, 32'h1);
    wr(OFS_CTRL_ONE, {4'h0, MODE_MASKLD});
    rdc(OFS_ADDR, 8'hff, MASK_RST);
    wr(OFS_ADDR, 8'h5a);
    rdc(OFS_ADDR, 8'hff, 8'h5a);
    wr(OFS_CTRL_ONE, 8'h00);
    rdc(OFS_ADDR, 8'hff, ADDR_RST);
    strap <= 1'b0;
    wr(OFS_CTRL_ONE, {4'h0, MODE_MASKLD});
    wr(OFS_ADDR, 8'h33);
    wr(OFS_CTRL_ONE, 8'h00);
    rdc(OFS_ADDR, 8'hff, 8'h33);
    strap <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      wr(OFS_CTRL_ONE, {4'h2, mode_tab[i]});
      repeat (4) @(posedge clock_in);
      chk({31'h0, poe.scl}, {31'h0, hold_m[i]});
      chk({31'h0, owned}, 32'h1);
    end
    wr(OFS_CTRL_ONE, {4'h3, MODE_SLV7});
    repeat (4) @(posedge clock_in);
    chk({31'h0, poe.scl}, 32'h0);
    wr(OFS_CTRL_ONE, {4'h2, MODE_MST});
    wr(OFS_ADDR, 8'h02);
    for (int i = 0; i < 2; i++) begin
      wr(OFS_CTRL_TWO, 8'h01 << i);
      poll(OFS_CTRL_TWO, 8'h01 << i);
      ack_en = (i == 0);
      wr(OFS_BUFFER, tx_tab[i]);
      wr(OFS_BUFFER, 8'hff);
      wr(OFS_CTRL_TWO, 8'h04);
      poll(OFS_STATUS, 8'h02);
      rdc(OFS_CTRL_TWO, 8'h04, 8'h00);
      rdc(OFS_CTRL_ONE, 8'hc0, 8'h80);
      rdc(OFS_CTRL_TWO, 8'h40, {1'b0, i[0], 6'h0});
      chk({23'h0, wire_sh}, {23'h0, tx_tab[i], i[0]});
      wr(OFS_CTRL_ONE, {4'h2, MODE_MST});
    end
    rd_mode = 1'b1;
    wr(OFS_CTRL_TWO, 8'h02);
    poll(OFS_CTRL_TWO, 8'h02);
    for (int i = 0; i < 2; i++) begin
      wr(OFS_CTRL_TWO, 8'h08);
      poll(OFS_CTRL_TWO, 8'h08);
    end
    rdc(OFS_CTRL_ONE, 8'h40, 8'h40);
    rdc(OFS_BUFFER, 8'hff, 8'h96);
    for (int i = 0; i < 2; i++) begin
      wr(OFS_CTRL_TWO, {2'b00, i[0], 5'h10});
      poll(OFS_CTRL_TWO, 8'h10);
      chk({31'h0, wire_sh[0]}, 32'(i));
    end
    wr(OFS_CTRL_TWO, 8'h04);
    poll(OFS_CTRL_TWO, 8'h04);
    chk({30'h0, scl_w, sda_w}, 32'h3);
    rd_mode = 1'b0;
    ack_en = 1'b0;
    strap <= 1'b0;
    wr(OFS_CTRL_ONE, {4'h3, MODE_SLV7});
    wr(OFS_ADDR, 8'ha0);
    wr(OFS_CTRL_TWO, 8'h84);
    for (int i = 0; i < 3; i++) begin
      frame(sl_tab[i], ack);
      chk({31'h0, ack}, {31'h0, i < 2});
      chk({31'h0, evt}, {31'h0, i < 2});
      rdc(OFS_BUFFER, 8'hff, (i == 0) ? 8'ha4 : 8'h00);
      wr(OFS_STATUS, 8'h04);
    end
    wr(OFS_CTRL_ONE, 8'h00);
    repeat (4) @(posedge clock_in);
    chk({31'h0, owned}, 32'h0);
    end_of_test();
  end
endmodule
